// File: core/crcss_defs.vh
`ifndef CRCSS_DEFS_VH
`define CRCSS_DEFS_VH

// ----------------------------------------
// Shift counter presets and widths
// ----------------------------------------
`define CRCSS_PRESET_8 3'h0
`define CRCSS_PRESET_6 3'h2
`define CRCSS_CNT_MAX 3'h7
`define CRCSS_DATA_W 16

// ----------------------------------------
// Mode bit positions within mode_bits
// ----------------------------------------
`define CRCSS_MODE_WIDE 0
`define CRCSS_MODE_LRC 1
`define CRCSS_MODE_CRC_IC 2
`define CRCSS_MODE_TWO_CHAR 3

// ----------------------------------------
// Reflected polynomials
// ----------------------------------------
`define CRCSS_POLY_16 16'hA001
`define CRCSS_POLY_CCITT 16'h8408
`define CRCSS_POLY_12 12'hF01

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CRCSS_DONE_RST 1'b1
`define CRCSS_DATA_RST 16'h0000
`define CRCSS_CHECK_RST 16'h0000
`define CRCSS_MOD2_RST 1'b0
`define CRCSS_QUO_RST 1'b0

`endif

// File: core/crcss_feedback.v
`include "crcss_defs.vh"

module crcss_feedback (
  block_check_char,
  data_lsb,
  wide_check_select,
  lrc_mode,
  crc_ic_mode,
  check_next,
  quotient_bit
);
  input wire [15:0] block_check_char;
  input wire data_lsb;
  input wire wide_check_select;
  input wire lrc_mode;
  input wire crc_ic_mode;
  output reg [15:0] check_next;
  output wire quotient_bit;

  wire fb;
  wire feedback_mux_select;
  reg [15:0] wide_next;
  reg [11:0] crc12_next;
  wire [3:0] mux_a;
  wire [3:0] mux_b;
  wire [3:0] mux_out;

  // ----------------------------------------
  // Quotient and selector control
  // ----------------------------------------
  assign fb = data_lsb ^ block_check_char[0];
  assign quotient_bit = fb;
  assign feedback_mux_select = ~lrc_mode & ~wide_check_select;

  // ----------------------------------------
  // Per-mode shift and feedback paths
  // ----------------------------------------
  always @* begin
    wide_next = {1'b0, block_check_char[15:1]};
    crc12_next = {1'b0, block_check_char[11:1]};
    if (lrc_mode) begin
      if (wide_check_select) begin
        wide_next = {fb, block_check_char[15:1]};
      end else begin
        wide_next = {8'h00, fb, block_check_char[7:1]};
      end
    end else if (fb) begin
      if (crc_ic_mode) begin
        wide_next = wide_next ^ `CRCSS_POLY_CCITT;
      end else begin
        wide_next = wide_next ^ `CRCSS_POLY_16;
      end
    end
    if (fb) begin
      crc12_next = crc12_next ^ `CRCSS_POLY_12;
    end
  end

  // ----------------------------------------
  // Four-bit selector on the low nibble
  // ----------------------------------------
  assign mux_a = ~crc12_next[3:0];
  assign mux_b = wide_next[3:0];
  assign mux_out = feedback_mux_select ? ~mux_a : mux_b;

  always @* begin
    if (feedback_mux_select) begin
      check_next = {4'h0, crc12_next[11:4], mux_out};
    end else begin
      check_next = {wide_next[15:4], mux_out};
    end
  end
endmodule // crcss_feedback

// File: core/crcss_core.v
`include "crcss_defs.vh"

module crcss_core #(
  parameter DATA_W = `CRCSS_DATA_W
) (
  clk,
  rst_b,
  data_wr,
  data_in,
  mode_bits,
  cycle_mode_enable,
  step_wr,
  clear_wr,
  data_reg_out,
  block_check_char,
  quotient_bit,
  done,
  load_shift_strobe,
  check_shift_strobe
);
  input wire clk;
  input wire rst_b;
  input wire data_wr;
  input wire [DATA_W-1:0] data_in;
  input wire [3:0] mode_bits;
  input wire cycle_mode_enable;
  input wire step_wr;
  input wire clear_wr;
  output wire [DATA_W-1:0] data_reg_out;
  output wire [15:0] block_check_char;
  output wire quotient_bit;
  output wire done;
  output wire load_shift_strobe;
  output wire check_shift_strobe;

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg [DATA_W-1:0] data_reg;
  reg [15:0] check_reg;
  reg done_reg;
  reg mod2_reg;
  reg [2:0] mod8_reg;
  reg [DATA_W-1:0] data_next;
  reg [15:0] check_reg_next;
  reg done_next;
  reg mod2_next;
  reg [2:0] mod8_next;
  reg mod8_step;
  reg count_wrap;
  reg quotient_reg;
  reg quotient_next;
  wire wide_check_select;
  wire lrc_mode;
  wire crc_ic_mode;
  wire two_char_load;
  wire clock_run;
  wire shift_pulse;
  wire [15:0] check_next;
  wire [2:0] preset;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Counter preset and step arithmetic
  // ----------------------------------------
  function [2:0] crcss_preset_of(
    input lrc_bit,
    input wide_bit
  );
    if (~lrc_bit & ~wide_bit) begin
      crcss_preset_of = `CRCSS_PRESET_6;
    end else begin
      crcss_preset_of = `CRCSS_PRESET_8;
    end
  endfunction

  function crcss_mod8_clock(
    input two_char,
    input half_state
  );
    if (two_char) begin
      crcss_mod8_clock = half_state;
    end else begin
      crcss_mod8_clock = 1'b1;
    end
  endfunction

  function [3:0] crcss_count_step(
    input [2:0] count
  );
    crcss_count_step = {(count == `CRCSS_CNT_MAX), count + 3'h1};
  endfunction

  // ----------------------------------------
  // Mode decode and shift clock gating
  // ----------------------------------------
  assign wide_check_select = mode_bits[`CRCSS_MODE_WIDE];
  assign lrc_mode = mode_bits[`CRCSS_MODE_LRC];
  assign crc_ic_mode = mode_bits[`CRCSS_MODE_CRC_IC];
  assign two_char_load = mode_bits[`CRCSS_MODE_TWO_CHAR];

  assign clock_run = ~data_wr & ~done_reg;
  assign shift_pulse = cycle_mode_enable ? clock_run :
    (step_wr & ~data_wr);

  assign preset = crcss_preset_of(lrc_mode, wide_check_select);

  // ----------------------------------------
  // Check feedback network
  // ----------------------------------------
  crcss_feedback u_feedback (
    .block_check_char(check_reg),
    .data_lsb(data_reg[0]),
    .wide_check_select(wide_check_select),
    .lrc_mode(lrc_mode),
    .crc_ic_mode(crc_ic_mode),
    .check_next(check_next),
    .quotient_bit()
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always @* begin
    data_next = data_reg;
    check_reg_next = check_reg;
    done_next = done_reg;
    mod2_next = mod2_reg;
    mod8_next = mod8_reg;
    mod8_step = 1'b0;
    count_wrap = 1'b0;
    if (clear_wr) begin
      check_reg_next = `CRCSS_CHECK_RST;
      done_next = 1'b1;
    end
    if (data_wr) begin
      data_next = data_in;
      done_next = 1'b0;
      mod8_next = preset;
      mod2_next = 1'b0;
    end else if (shift_pulse) begin
      data_next = {1'b0, data_reg[DATA_W-1:1]};
      check_reg_next = check_next;
      if (two_char_load) begin
        mod2_next = ~mod2_reg;
      end
      mod8_step = crcss_mod8_clock(two_char_load, mod2_reg);
      if (mod8_step) begin
        {count_wrap, mod8_next} = crcss_count_step(mod8_reg);
        if (count_wrap) begin
          done_next = 1'b1;
        end
      end
    end
    quotient_next = data_next[0] ^ check_reg_next[0];
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      data_reg <= `CRCSS_DATA_RST;
      check_reg <= `CRCSS_CHECK_RST;
      done_reg <= `CRCSS_DONE_RST;
      mod2_reg <= `CRCSS_MOD2_RST;
      mod8_reg <= `CRCSS_PRESET_8;
    end else begin
      data_reg <= data_next;
      check_reg <= check_reg_next;
      done_reg <= done_next;
      mod2_reg <= mod2_next;
      mod8_reg <= mod8_next;
    end
  end

  // ----------------------------------------
  // Quotient status register
  // ----------------------------------------
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      quotient_reg <= `CRCSS_QUO_RST;
    end else begin
      quotient_reg <= quotient_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_reg_out = data_reg;
  assign block_check_char = check_reg;
  assign done = done_reg;
  assign quotient_bit = quotient_reg;
  assign load_shift_strobe = data_wr | shift_pulse;
  assign check_shift_strobe = shift_pulse & ~data_wr;
endmodule // crcss_core

// File: dv/crcss_host_model.sv
module crcss_host_model (
  input wire logic clk,
  output logic data_wr,
  output logic [15:0] data_in,
  output logic [3:0] mode_bits,
  output logic cycle_mode_enable,
  output logic step_wr,
  output logic clear_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] MODE_CRC16_TWO = 4'h9;
  localparam logic [3:0] MODE_LRC8 = 4'h2;
  localparam logic [3:0] MODE_CRC12 = 4'h0;
  initial begin
    data_wr = 1'b0;
    data_in = 16'h0000;
    mode_bits = 4'h0;
    cycle_mode_enable = 1'b1;
    step_wr = 1'b0;
    clear_wr = 1'b0;
  end
  task set_mode(input logic [3:0] m, input logic cyc);
    @(posedge clk);
    mode_bits <= m;
    cycle_mode_enable <= cyc;
  endtask
  task pulse(input logic clr);
    @(posedge clk);
    if (clr) clear_wr <= 1'b1;
    else step_wr <= 1'b1;
    @(posedge clk);
    clear_wr <= 1'b0;
    step_wr <= 1'b0;
  endtask
  // Write selection is dropped after one cycle and the lines change.
  task write_data(input logic [15:0] d);
    @(posedge clk);
    data_wr <= 1'b1;
    data_in <= d;
    @(posedge clk);
    data_wr <= 1'b0;
    data_in <= ~d;
  endtask
endmodule // crcss_host_model

// File: dv/crcss_core_assertions.sv
module crcss_core_assertions #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [3:0] mode_bits,
  input wire logic cycle_mode_enable,
  input wire logic step_wr,
  input wire logic clear_wr,
  input wire logic [DATA_W-1:0] data_reg_out,
  input wire logic [15:0] block_check_char,
  input wire logic quotient_bit,
  input wire logic done,
  input wire logic load_shift_strobe,
  input wire logic check_shift_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_load;
    data_wr ##1 (!data_wr && !clear_wr && cycle_mode_enable);
  endsequence
  chk_quotient_xor: assert property (
    quotient_bit == (data_reg_out[0] ^ block_check_char[0]))
    else $error("quotient bit wrong");
  chk_strobe_pair: assert property (
    check_shift_strobe |-> load_shift_strobe)
    else $error("check shift without data shift");
  chk_wr_noshift: assert property (
    data_wr |-> load_shift_strobe && !check_shift_strobe)
    else $error("shift during load");
  chk_wr_done: assert property (
    data_wr |=> !done) else $error("done not cleared");
  chk_wr_loads: assert property (
    data_wr |=> data_reg_out == $past(data_in))
    else $error("parallel load wrong");
  chk_shift_right: assert property (
    check_shift_strobe |=>
      data_reg_out[DATA_W-2:0] == $past(data_reg_out[DATA_W-1:1]))
    else $error("data not shifted right");
  chk_sum_hold: assert property (
    !check_shift_strobe && !clear_wr |=> $stable(block_check_char))
    else $error("check register moved");
  chk_done_idle: assert property (
    cycle_mode_enable && done && !step_wr |-> !check_shift_strobe)
    else $error("shift after done");
  chk_step_one: assert property (
    !cycle_mode_enable && !data_wr |-> check_shift_strobe == step_wr)
    else $error("step shift wrong");
  chk_run_starts: assert property (
    s_load |-> check_shift_strobe) else $error("clock did not start");
endmodule // crcss_core_assertions

// File: dv/crc_shift_sequencer_tb.sv
module crc_shift_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DATA_W = 16;
  logic clk, rst_b, data_wr, cycle_mode_enable, step_wr, clear_wr;
  logic [15:0] data_in, data_reg_out, block_check_char;
  logic [3:0] mode_bits;
  logic quotient_bit, done, load_shift_strobe, check_shift_strobe;
  int error_cnt, n_checks;
  crcss_host_model host_u (.clk(clk), .data_wr(data_wr),
    .data_in(data_in), .mode_bits(mode_bits),
    .cycle_mode_enable(cycle_mode_enable), .step_wr(step_wr),
    .clear_wr(clear_wr));
  crcss_core #(.DATA_W(DATA_W)) dut_u (.clk(clk), .rst_b(rst_b),
    .data_wr(data_wr), .data_in(data_in), .mode_bits(mode_bits),
    .cycle_mode_enable(cycle_mode_enable), .step_wr(step_wr),
    .clear_wr(clear_wr), .data_reg_out(data_reg_out),
    .block_check_char(block_check_char), .quotient_bit(quotient_bit),
    .done(done), .load_shift_strobe(load_shift_strobe),
    .check_shift_strobe(check_shift_strobe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task run_clear;
    host_u.set_mode(host_u.MODE_LRC8, 1'b0);
    host_u.write_data(16'h00ff);
    host_u.pulse(1'b0);
    @(negedge clk);
    check({15'h0000, done}, 16'h0000);
    check(block_check_char, 16'h0080);
    host_u.pulse(1'b1);
    @(negedge clk);
    check({15'h0000, done}, 16'h0001);
    check(block_check_char, 16'h0000);
  endtask
  task run_cycle(input logic [3:0] m, input logic [15:0] exp,
    input logic [15:0] exp_data, input logic [15:0] exp_sum);
    logic [15:0] n;
    n = 16'h0000;
    host_u.set_mode(m, 1'b1);
    host_u.write_data(16'h5a3c);
    repeat (40) begin
      @(negedge clk);
      if (done === 1'b1) break;
      if (check_shift_strobe === 1'b1) n++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      conclude;
    end else begin
      check(n, exp);
      check(data_reg_out, exp_data);
      check(block_check_char, exp_sum);
    end
  endtask
  task run_step;
    host_u.set_mode(host_u.MODE_LRC8, 1'b0);
    host_u.write_data(16'h00b6);
    repeat (3) host_u.pulse(1'b0);
    @(negedge clk);
    check({3'h0, data_reg_out[12:0]}, 16'h0016);
    check({15'h0000, done}, 16'h0000);
    check(block_check_char, 16'h00f2);
    check({15'h0000, quotient_bit}, 16'h0000);
    repeat (5) host_u.pulse(1'b0);
    @(negedge clk);
    check({15'h0000, done}, 16'h0001);
    check(block_check_char, 16'h0027);
    check({15'h0000, quotient_bit}, 16'h0001);
  endtask
  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run_clear;
    run_cycle(host_u.MODE_LRC8, 16'h0008, 16'h005a, 16'h003c);
    run_cycle(host_u.MODE_CRC12, 16'h0006, 16'h0168, 16'h0000);
    run_cycle(host_u.MODE_CRC16_TWO, 16'h0010, 16'h0000, 16'h3b91);
    run_step;
    conclude;
  end
endmodule // crc_shift_sequencer_tb
bind crcss_core crcss_core_assertions #(.DATA_W(DATA_W)) chk_u (
  .clk(clk), .rst_b(rst_b), .data_wr(data_wr), .data_in(data_in),
  .mode_bits(mode_bits), .cycle_mode_enable(cycle_mode_enable),
  .step_wr(step_wr), .clear_wr(clear_wr), .data_reg_out(data_reg_out),
  .block_check_char(block_check_char), .quotient_bit(quotient_bit),
  .done(done), .load_shift_strobe(load_shift_strobe),
  .check_shift_strobe(check_shift_strobe));
